// File: design/hos_pkg.sv
// Constants, carriers and settings of the harmonic overcurrent stage.
// Assumes magnitudes in 0.01 units and times in 5 ms program cycles.
package hos_pkg;
	localparam int NUM_STAGES = 4;
	localparam int NUM_HARM = 12;
	localparam int NUM_CHAN = 5;
	localparam int REC_DEPTH = 12;
	localparam int CYCLE_MS = 5;
	localparam int PRE_TRIG_MS = 20;
	localparam int PRE_FAULT_MS = 200;
	localparam int BLOCK_LEAD_MS = 5;
	localparam int PRE_TRIG_CYC = PRE_TRIG_MS / CYCLE_MS;
	localparam int PRE_FAULT_CYC = PRE_FAULT_MS / CYCLE_MS;
	localparam int HP_W = 6;
	// 1800 s in program cycles
	localparam logic [18:0] TIME_MAX = 19'h5_7E40;
	// 100000.00 in 0.01 steps
	localparam logic [23:0] RATIO_MAX = 24'h98_9680;
	localparam logic [23:0] RATIO_ONE = 24'h00_0064;
	localparam logic [39:0] FULL_PCT = 40'h00_0000_0064;
	localparam logic [39:0] HYST_PCT = 40'h00_0000_0061;
	localparam logic [31:0] REL_SCALE = 32'h0000_2710;
	localparam logic [14:0] PU_MIN = 15'h0005;
	localparam logic [14:0] PU_MAX = 15'h00C8;
	localparam logic [14:0] PU_DEF = 15'h0014;
	localparam logic [14:0] REL_MIN = 15'h01F4;
	localparam logic [14:0] REL_MAX = 15'h4E20;
	localparam logic [18:0] OPDLY_DEF = 19'h0_0014;
	localparam logic [18:0] RSTDLY_DEF = 19'h0_0000;
	// APB map: global words, 16-byte blocks per stage, then one shared record block
	localparam logic [3:0] BLK_GLOBAL = 4'h0;
	localparam logic [3:0] BLK_CFG = 4'h1;
	localparam logic [3:0] BLK_STAT = 4'h5;
	localparam logic [3:0] BLK_CNT = 4'h9;
	localparam logic [3:0] BLK_REC = 4'hD;
	localparam logic [1:0] OFS_GLOBAL = 2'h0;
	localparam logic [1:0] OFS_CNT_CLR = 2'h1;
	localparam logic [1:0] OFS_REC_SEL = 2'h2;
	localparam logic [1:0] OFS_STAMP = 2'h3;

	typedef logic [15:0] hos_mag_t;
	typedef struct packed {
		hos_mag_t [NUM_HARM-1:0] harm;
		hos_mag_t fund;
	} hos_chan_t;
	typedef enum logic [1:0] {
		ST_NORMAL = 2'b00,
		ST_START = 2'b01,
		ST_TRIP = 2'b11,
		ST_BLOCKED = 2'b10
	} hos_cond_t;
	typedef enum logic [1:0] {
		IN_PHASE = 2'b00,
		IN_RES1 = 2'b01,
		IN_RES2 = 2'b10
	} hos_insel_t;
	typedef struct packed {
		logic [3:0] harm_sel;
		logic rel_mode;
		hos_insel_t in_sel;
		logic idmt;
		hos_cond_t force_to;
		logic ev_on;
		logic ev_off;
	} hos_cfg_t;
	localparam logic [11:0] CFG_RST = 12'h003;
	typedef struct packed {
		logic start_on;
		logic start_off;
		logic trip_on;
		logic trip_off;
		logic block_on;
		logic block_off;
	} hos_event_t;
	typedef struct packed {
		logic [31:0] stamp;
		logic [2:0] event_id;
		logic [2:0] phases;
		hos_mag_t pre20;
		hos_mag_t trig;
		hos_mag_t pre200;
		logic [19:0] remain;
		logic [2:0] group;
	} hos_rec_t;
endpackage : hos_pkg

// File: design/hos_divider.sv
// Serial restoring divider, one quotient bit per clock.
// Assumes go is a one-cycle request while idle; divide by zero gives all ones.
`timescale 1ns/1ps
module hos_divider #(
	parameter int NUM_W = 40,
	parameter int DEN_W = 32
) (
	// Clock, reset, enable
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic ce,
	// Request
	input wire logic go,
	input wire logic [NUM_W-1:0] num,
	input wire logic [DEN_W-1:0] den,
	// Answer
	output logic busy,
	output logic done,
	output logic [NUM_W-1:0] quot
);
	localparam int CNT_W = $clog2(NUM_W + 1);
	logic [DEN_W:0] rem;
	logic [DEN_W:0] trial;
	logic [CNT_W-1:0] cnt;

	assign trial = {rem[DEN_W-1:0], quot[NUM_W-1]};

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			busy <= 1'b0;
			done <= 1'b0;
			quot <= '0;
			rem <= '0;
			cnt <= '0;
		end else if (ce) begin
			if (go && !busy) begin
				quot <= num;
				rem <= '0;
				cnt <= CNT_W'(NUM_W);
				busy <= 1'b1;
				done <= 1'b0;
			end else if (busy) begin
				if (trial >= {1'b0, den}) begin
					rem <= trial - {1'b0, den};
					quot <= {quot[NUM_W-2:0], 1'b1};
				end else begin
					rem <= trial;
					quot <= {quot[NUM_W-2:0], 1'b0};
				end
				cnt <= cnt - CNT_W'(1);
				if (cnt == CNT_W'(1)) begin
					busy <= 1'b0;
					done <= 1'b1;
				end
			end else begin
				done <= 1'b0;
			end
		end
	end
endmodule : hos_divider

// File: design/hos_stage.sv
// One stage: harmonic pick-up with hysteresis, blocking, DT/IDMT timing.
// Assumes cycle_tick marks each program cycle and block_level is synchronised.
`timescale 1ns/1ps
module hos_stage
	import hos_pkg::*;
(
	// Clock, reset, enable
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic ce,
	// Program cycle and block
	input wire logic cycle_tick,
	input wire logic block_level,
	// Settings
	input wire hos_cfg_t cfg,
	input wire logic [14:0] pickup,
	input wire logic [18:0] op_delay,
	input wire logic [18:0] rst_delay,
	// Measurements
	input wire hos_chan_t [NUM_CHAN-1:0] meas,
	// State and info
	output hos_cond_t cond,
	output logic [2:0] phases,
	output hos_mag_t meas_mag,
	output logic [23:0] ratio,
	output logic [18:0] expect_time,
	output logic signed [19:0] remain_time
);
	logic [3:0] hsel;
	logic [14:0] set_eff;
	hos_mag_t harm [3];
	logic [31:0] lhs [3];
	logic [31:0] rhs [3];
	logic [2:0] next_picked;
	logic [1:0] big;
	logic [18:0] elapsed;
	logic [18:0] rel_cnt;
	logic [39:0] acc;
	logic [39:0] next_acc;
	logic [23:0] excess;
	logic trip_due;
	logic div_go;
	logic div_busy;
	logic div_done;
	logic div_phase;
	logic [39:0] div_num;
	logic [39:0] div_quot;
	logic [31:0] div_den;

	assign hsel = (cfg.harm_sel < 4'(NUM_HARM)) ? cfg.harm_sel : 4'h0;

	always_comb begin
		if (cfg.rel_mode) begin
			set_eff = (pickup < REL_MIN) ? REL_MIN : (pickup > REL_MAX) ? REL_MAX : pickup;
		end else begin
			set_eff = (pickup < PU_MIN) ? PU_MIN : (pickup > PU_MAX) ? PU_MAX : pickup;
		end
	end

	genvar k;
	generate
		for (k = 0; k < 3; k++) begin : g_ph
			logic use_k;
			logic [2:0] ch;
			hos_mag_t fund;
			assign use_k = (cfg.in_sel == IN_PHASE) || (k == 0);
			assign ch = (cfg.in_sel == IN_PHASE) ? 3'(k) : (cfg.in_sel == IN_RES2) ? 3'd4 : 3'd3;
			assign harm[k] = use_k ? meas[ch].harm[hsel] : '0;
			assign fund = use_k ? meas[ch].fund : '0;
			// Relative mode cross-multiplies to avoid a divide
			assign lhs[k] = cfg.rel_mode ? 32'(harm[k]) * REL_SCALE : 32'(harm[k]);
			assign rhs[k] = cfg.rel_mode ? 32'(set_eff) * 32'(fund) : 32'(set_eff);
			// No harmonic at all releases, even with no fundamental
			assign next_picked[k] = use_k && (phases[k] ? ((lhs[k] != 32'h0000_0000) &&
				(40'(lhs[k]) * FULL_PCT >= 40'(rhs[k]) * HYST_PCT)) : (lhs[k] > rhs[k]));
		end
	endgenerate

	always_comb begin
		big = (lhs[1] > lhs[0]) ? 2'd1 : 2'd0;
		if (lhs[2] > lhs[big]) begin
			big = 2'd2;
		end
		excess = (ratio > RATIO_ONE) ? ratio - RATIO_ONE : 24'h00_0000;
		next_acc = acc + 40'(excess);
		if (cfg.idmt) begin
			trip_due = next_acc >= 40'(op_delay) * FULL_PCT;
		end else begin
			trip_due = (elapsed + 19'h0_0001) >= op_delay;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cond <= ST_NORMAL;
			phases <= 3'h0;
			meas_mag <= '0;
			elapsed <= '0;
			rel_cnt <= '0;
			acc <= '0;
		end else if (ce && cycle_tick) begin
			phases <= next_picked;
			meas_mag <= harm[big];
			if ((|next_picked) && !block_level) begin
				rel_cnt <= '0;
				acc <= next_acc;
				if (elapsed != TIME_MAX) begin
					elapsed <= elapsed + 19'h0_0001;
				end
				if (cond == ST_TRIP || trip_due) begin
					cond <= ST_TRIP;
				end else begin
					cond <= ST_START;
				end
			end else begin
				cond <= (|next_picked) ? ST_BLOCKED : ST_NORMAL;
				if (rel_cnt >= rst_delay) begin
					elapsed <= '0;
					acc <= '0;
				end else begin
					rel_cnt <= rel_cnt + 19'h0_0001;
				end
			end
		end
	end

	// Divider alternates: ratio, then expected IDMT time
	assign div_num = div_phase ? 40'(op_delay) * FULL_PCT : 40'(lhs[big]) * FULL_PCT;
	assign div_den = div_phase ? 32'(excess) : rhs[big];

	hos_divider #(
		.NUM_W(40),
		.DEN_W(32)
	) u_div (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.go(div_go),
		.num(div_num),
		.den(div_den),
		.busy(div_busy),
		.done(div_done),
		.quot(div_quot)
	);

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			div_go <= 1'b0;
			div_phase <= 1'b0;
			ratio <= '0;
			expect_time <= '0;
		end else if (ce) begin
			div_go <= !div_go && !div_busy && !div_done;
			if (div_done) begin
				div_phase <= !div_phase;
				if (!div_phase) begin
					ratio <= (div_quot > 40'(RATIO_MAX)) ? RATIO_MAX : div_quot[23:0];
				end else if (!cfg.idmt) begin
					expect_time <= op_delay;
				end else begin
					expect_time <= (div_quot > 40'(TIME_MAX)) ? TIME_MAX : div_quot[18:0];
				end
			end
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			remain_time <= '0;
		end else if (ce) begin
			if (cond == ST_START || cond == ST_TRIP) begin
				remain_time <= $signed({1'b0, expect_time}) - $signed({1'b0, elapsed});
			end else begin
				remain_time <= '0;
			end
		end
	end
endmodule : hos_stage

// File: design/hos_harmonic_overcurrent_stage.sv
// Top: four harmonic overcurrent stages, APB registers, events,
// counters and fault records. Assumes measurements arrive with cycle_tick.
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module hos_harmonic_overcurrent_stage
	import hos_pkg::*;
(
	// Clock, reset, enable
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Measurements, one set per program cycle
	input wire logic cycle_tick,
	input wire hos_chan_t [NUM_CHAN-1:0] meas,
	// Blocking pins, one per stage
	input wire logic [NUM_STAGES-1:0] block_in,
	// Stage outputs
	output logic [NUM_STAGES-1:0] stage_start,
	output logic [NUM_STAGES-1:0] stage_trip,
	output logic [NUM_STAGES-1:0] stage_blocked,
	// Events
	output hos_event_t [NUM_STAGES-1:0] event_pulse,
	output logic [31:0] event_stamp
);
	logic [3:0] blk;
	logic [1:0] lo;
	logic [1:0] sidx;
	logic setup;
	logic addr_ok;
	logic wr_en;
	logic [31:0] rd_data;
	logic force_en;
	logic [2:0] group;
	logic [7:0] rec_sel;
	logic [31:0] stamp;
	logic [NUM_STAGES-1:0] blk_s1;
	logic [NUM_STAGES-1:0] blk_s2;
	logic [NUM_STAGES-1:0] cnt_clr;
	logic [NUM_STAGES-1:0] eff_start;
	logic [NUM_STAGES-1:0] eff_trip;
	logic [NUM_STAGES-1:0] eff_blocked;
	hos_cfg_t cfg [NUM_STAGES];
	logic [14:0] pickup [NUM_STAGES];
	logic [18:0] op_delay [NUM_STAGES];
	logic [18:0] rst_delay [NUM_STAGES];
	hos_cond_t st_cond [NUM_STAGES];
	hos_cond_t eff_cond [NUM_STAGES];
	logic [2:0] st_phases [NUM_STAGES];
	hos_mag_t st_mag [NUM_STAGES];
	logic [23:0] st_ratio [NUM_STAGES];
	logic [18:0] st_expect [NUM_STAGES];
	logic signed [19:0] st_remain [NUM_STAGES];
	logic [15:0] cnt_rd [NUM_STAGES][3];
	hos_rec_t rec_rd [NUM_STAGES];
	logic [3:0] rec_cnt [NUM_STAGES];

	// APB decode
	assign blk = paddr[7:4];
	assign lo = paddr[3:2];
	assign sidx = 2'(blk - BLK_CFG);
	assign setup = psel && !penable && !pready;
	assign addr_ok = (blk <= BLK_REC) && !(blk >= BLK_CNT && blk < BLK_REC && lo == 2'h3);
	assign wr_en = psel && penable && pready && pwrite && !pslverr;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (ce) begin
			pready <= setup;
			pslverr <= setup && !addr_ok;
			if (setup) begin
				prdata <= (addr_ok && !pwrite) ? rd_data : 32'h0000_0000;
			end
		end
	end

	always_comb begin
		rd_data = 32'h0000_0000;
		if (blk == BLK_GLOBAL) begin
			case (lo)
				OFS_GLOBAL: rd_data = {28'h000_0000, group, force_en};
				OFS_REC_SEL: rd_data = {20'h0_0000, rec_cnt[rec_sel[1:0]], rec_sel};
				OFS_STAMP: rd_data = stamp;
				default: rd_data = 32'h0000_0000;
			endcase
		end else if (blk < BLK_STAT) begin
			case (lo)
				2'h0: rd_data = {20'h0_0000, cfg[sidx]};
				2'h1: rd_data = {17'h0_0000, pickup[sidx]};
				2'h2: rd_data = {13'h0000, op_delay[sidx]};
				default: rd_data = {13'h0000, rst_delay[sidx]};
			endcase
		end else if (blk < BLK_CNT) begin
			case (lo)
				2'h0: rd_data = {29'h0000_0000, st_phases[sidx] != 3'h0, eff_cond[sidx]};
				2'h1: rd_data = {8'h00, st_ratio[sidx]};
				2'h2: rd_data = {13'h0000, st_expect[sidx]};
				default: rd_data = 32'(st_remain[sidx]);
			endcase
		end else if (blk < BLK_REC) begin
			if (lo != 2'h3) begin
				rd_data = {16'h0000, cnt_rd[sidx][lo]};
			end
		end else if (blk == BLK_REC) begin
			case (lo)
				2'h0: rd_data = rec_rd[rec_sel[1:0]].stamp;
				2'h1: rd_data = {rec_rd[rec_sel[1:0]].pre20, rec_rd[rec_sel[1:0]].trig};
				2'h2: rd_data = {rec_rd[rec_sel[1:0]].pre200, 7'h00, rec_rd[rec_sel[1:0]].event_id,
					rec_rd[rec_sel[1:0]].phases, rec_rd[rec_sel[1:0]].group};
				default: rd_data = 32'($signed(rec_rd[rec_sel[1:0]].remain));
			endcase
		end
	end

	// Global registers
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			force_en <= 1'b0;
			group <= 3'h0;
			rec_sel <= 8'h00;
		end else if (ce && wr_en && blk == BLK_GLOBAL) begin
			if (lo == OFS_GLOBAL) begin
				force_en <= pwdata[0];
				group <= pwdata[3:1];
			end else if (lo == OFS_REC_SEL) begin
				rec_sel <= pwdata[7:0];
			end
		end
	end

	assign cnt_clr = (wr_en && blk == BLK_GLOBAL && lo == OFS_CNT_CLR) ? pwdata[NUM_STAGES-1:0] : '0;

	// Blocking pins and program-cycle time base
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			blk_s1 <= '0;
			blk_s2 <= '0;
			stamp <= 32'h0000_0000;
		end else if (ce) begin
			blk_s1 <= block_in;
			blk_s2 <= blk_s1;
			if (cycle_tick) begin
				stamp <= stamp + 32'h0000_0001;
			end
		end
	end

	genvar s;
	generate
		for (s = 0; s < NUM_STAGES; s++) begin : g_stage
			hos_mag_t hist [PRE_FAULT_CYC];
			hos_rec_t mem [REC_DEPTH];
			logic [HP_W-1:0] hp;
			logic [HP_W-1:0] hp20;
			logic [3:0] wp;
			logic [3:0] rcnt;
			logic [15:0] cnt [3];
			logic [2:0] on_edge;

			// Settings registers, taken live by the running stage
			always_ff @(posedge sys_clk or posedge sys_rst) begin
				if (sys_rst) begin
					cfg[s] <= hos_cfg_t'(CFG_RST);
					pickup[s] <= PU_DEF;
					op_delay[s] <= OPDLY_DEF;
					rst_delay[s] <= RSTDLY_DEF;
				end else if (ce && wr_en && blk >= BLK_CFG && blk < BLK_STAT && sidx == 2'(s)) begin
					case (lo)
						2'h0: cfg[s] <= hos_cfg_t'(pwdata[11:0]);
						2'h1: pickup[s] <= pwdata[14:0];
						2'h2: op_delay[s] <= pwdata[18:0];
						default: rst_delay[s] <= pwdata[18:0];
					endcase
				end
			end

			hos_stage u_stage (
				.sys_clk(sys_clk),
				.sys_rst(sys_rst),
				.ce(ce),
				.cycle_tick(cycle_tick),
				.block_level(blk_s2[s]),
				.cfg(cfg[s]),
				.pickup(pickup[s]),
				.op_delay(op_delay[s]),
				.rst_delay(rst_delay[s]),
				.meas(meas),
				.cond(st_cond[s]),
				.phases(st_phases[s]),
				.meas_mag(st_mag[s]),
				.ratio(st_ratio[s]),
				.expect_time(st_expect[s]),
				.remain_time(st_remain[s])
			);

			assign eff_cond[s] = force_en ? cfg[s].force_to : st_cond[s];
			assign eff_start[s] = (eff_cond[s] == ST_START) || (eff_cond[s] == ST_TRIP);
			assign eff_trip[s] = eff_cond[s] == ST_TRIP;
			assign eff_blocked[s] = eff_cond[s] == ST_BLOCKED;
			assign on_edge = {eff_trip[s] & ~stage_trip[s], eff_blocked[s] & ~stage_blocked[s],
				eff_start[s] & ~stage_start[s]};

			// Counters; an increment in the clear cycle survives as one
			for (genvar c = 0; c < 3; c++) begin : g_cnt
				always_ff @(posedge sys_clk or posedge sys_rst) begin
					if (sys_rst) begin
						cnt[c] <= 16'h0000;
					end else if (ce) begin
						if (cnt_clr[s]) begin
							cnt[c] <= {15'h0000, on_edge[c]};
						end else if (on_edge[c]) begin
							cnt[c] <= cnt[c] + 16'h0001;
						end
					end
				end
			end
			assign cnt_rd[s][0] = cnt[0];
			assign cnt_rd[s][1] = cnt[2];
			assign cnt_rd[s][2] = cnt[1];

			// Magnitude history for the pre-trigger and pre-fault values
			assign hp20 = (hp >= HP_W'(PRE_TRIG_CYC)) ? hp - HP_W'(PRE_TRIG_CYC) :
				hp + HP_W'(PRE_FAULT_CYC - PRE_TRIG_CYC);
			always_ff @(posedge sys_clk or posedge sys_rst) begin
				if (sys_rst) begin
					hp <= '0;
				end else if (ce && cycle_tick) begin
					hp <= (hp == HP_W'(PRE_FAULT_CYC - 1)) ? '0 : hp + HP_W'(1);
				end
			end
			always_ff @(posedge sys_clk) begin
				if (ce && cycle_tick) begin
					hist[hp] <= st_mag[s];
				end
			end

			// Rolling fault records
			always_ff @(posedge sys_clk or posedge sys_rst) begin
				if (sys_rst) begin
					wp <= 4'h0;
					rcnt <= 4'h0;
				end else if (ce && (|on_edge)) begin
					wp <= (wp == 4'(REC_DEPTH - 1)) ? 4'h0 : wp + 4'h1;
					if (rcnt != 4'(REC_DEPTH)) begin
						rcnt <= rcnt + 4'h1;
					end
				end
			end
			always_ff @(posedge sys_clk) begin
				if (ce && (|on_edge)) begin
					mem[wp] <= '{stamp: stamp, event_id: on_edge, phases: st_phases[s],
						pre20: hist[hp20], trig: st_mag[s], pre200: hist[hp],
						remain: st_remain[s], group: group};
				end
			end
			assign rec_rd[s] = (rec_sel[7:4] < 4'(REC_DEPTH) && rec_sel[7:4] < rcnt) ? mem[rec_sel[7:4]] : '0;
			assign rec_cnt[s] = rcnt;
		end
	endgenerate

	// Stage outputs and filtered events
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			stage_start <= '0;
			stage_trip <= '0;
			stage_blocked <= '0;
			event_pulse <= '0;
			event_stamp <= 32'h0000_0000;
		end else if (ce) begin
			stage_start <= eff_start;
			stage_trip <= eff_trip;
			stage_blocked <= eff_blocked;
			event_stamp <= stamp;
			for (int i = 0; i < NUM_STAGES; i++) begin
				event_pulse[i].start_on <= cfg[i].ev_on & eff_start[i] & ~stage_start[i];
				event_pulse[i].start_off <= cfg[i].ev_off & ~eff_start[i] & stage_start[i];
				event_pulse[i].trip_on <= cfg[i].ev_on & eff_trip[i] & ~stage_trip[i];
				event_pulse[i].trip_off <= cfg[i].ev_off & ~eff_trip[i] & stage_trip[i];
				event_pulse[i].block_on <= cfg[i].ev_on & eff_blocked[i] & ~stage_blocked[i];
				event_pulse[i].block_off <= cfg[i].ev_off & ~eff_blocked[i] & stage_blocked[i];
			end
		end
	end
endmodule : hos_harmonic_overcurrent_stage

// File: verification/hos_harmonic_overcurrent_stage_sva.sv
// Checker for the harmonic overcurrent top: APB timing and stage 0 outputs.
// Assumes stage 0 is only ever forced to Normal.
`timescale 1ns/1ps
module hos_checker import hos_pkg::*; (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic ce,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// Stage side
	input wire logic cycle_tick,
	input wire logic [NUM_STAGES-1:0] stage_start,
	input wire logic [NUM_STAGES-1:0] stage_trip,
	input wire logic [NUM_STAGES-1:0] stage_blocked,
	input wire hos_event_t [NUM_STAGES-1:0] event_pulse
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);
	sequence s_setup;
		psel && !penable && ce;
	endsequence
	property p_rdy;
		s_setup |=> pready;
	endproperty
	property p_one;
		pready && ce |=> !pready;
	endproperty
	property p_err;
		pslverr |-> pready;
	endproperty
	property p_trip;
		stage_trip[0] |-> stage_start[0];
	endproperty
	property p_excl;
		stage_blocked[0] |-> !stage_start[0];
	endproperty
	property p_evs;
		event_pulse[0].start_on |-> $rose(stage_start[0]);
	endproperty
	property p_evt;
		event_pulse[0].trip_on |-> $rose(stage_trip[0]) ##1 !event_pulse[0].trip_on;
	endproperty
	property p_evb;
		event_pulse[0].block_on |-> $rose(stage_blocked[0]);
	endproperty
	property p_tick;
		$rose(stage_start[0]) |-> $past(cycle_tick, 2);
	endproperty
	a_rdy: assert property (p_rdy) else $error("pready missing after setup");
	a_one: assert property (p_one) else $error("pready longer than one cycle");
	a_err: assert property (p_err) else $error("pslverr without pready");
	a_trip: assert property (p_trip) else $error("trip without start");
	a_excl: assert property (p_excl) else $error("blocked with start");
	a_evs: assert property (p_evs) else $error("start event mistimed");
	a_evt: assert property (p_evt) else $error("trip event mistimed");
	a_evb: assert property (p_evb) else $error("block event mistimed");
	a_tick: assert property (p_tick) else $error("start not tick aligned");
endmodule : hos_checker
bind hos_harmonic_overcurrent_stage hos_checker u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .ce(ce),
	.psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .cycle_tick(cycle_tick),
	.stage_start(stage_start), .stage_trip(stage_trip), .stage_blocked(stage_blocked),
	.event_pulse(event_pulse));

// File: verification/test_harmonic_overcurrent_stage.sv
// Self-checking bench for the harmonic overcurrent top over APB.
// Assumes zero-wait APB and ticks 101 clocks apart.
`timescale 1ns/1ps
module test_harmonic_overcurrent_stage import hos_pkg::*;;
	typedef struct packed {
		logic [11:0] cf;
		logic [14:0] pk;
		logic [2:0] ch;
		logic [3:0] ix;
		logic [15:0] mg;
		logic [15:0] fd;
		logic ex;
	} hos_row_t;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic cycle_tick = 1'b0;
	logic ce = 1'b1;
	logic [31:0] event_stamp;
	int n_tick = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic [31:0] r;
	logic pready;
	logic pslverr;
	logic e;
	logic [3:0] block_in = 4'h0;
	logic [3:0] stage_start;
	logic [3:0] stage_trip;
	logic [3:0] stage_blocked;
	hos_chan_t [NUM_CHAN-1:0] meas = '0;
	hos_chan_t [NUM_CHAN-1:0] m;
	int errors = 0;
	int n_tests = 0;
	hos_row_t rows [8] = '{
		'{12'h003, 15'h14, 3'h0, 4'h0, 16'h15, 16'h0, 1'b1},
		'{12'hB03, 15'h14, 3'h1, 4'hB, 16'h15, 16'h0, 1'b1},
		'{12'h603, 15'h14, 3'h2, 4'h6, 16'h14, 16'h0, 1'b0},
		'{12'h023, 15'h14, 3'h3, 4'h0, 16'h15, 16'h0, 1'b1},
		'{12'h043, 15'h14, 3'h4, 4'h0, 16'h15, 16'h0, 1'b1},
		'{12'h043, 15'h14, 3'h0, 4'h0, 16'h5A, 16'h0, 1'b0},
		'{12'h083, 15'h7D0, 3'h0, 4'h0, 16'h1E, 16'h64, 1'b1},
		'{12'h083, 15'h7D0, 3'h0, 4'h0, 16'h1E, 16'hC8, 1'b0}
	};
	hos_harmonic_overcurrent_stage dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cycle_tick(cycle_tick), .meas(meas), .block_in(block_in),
		.stage_start(stage_start), .stage_trip(stage_trip), .stage_blocked(stage_blocked),
		.event_pulse(), .event_stamp(event_stamp));
	initial begin
		forever #50 sys_clk = ~sys_clk;
	end
	task automatic complete_run();
		$display("errors=%0d tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_tests++;
		if (g !== x) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, x);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask : apb
	task automatic tk(input int n);
		repeat (n) begin
			n_tick++;
			cycle_tick <= 1'b1;
			@(posedge sys_clk);
			cycle_tick <= 1'b0;
			repeat (100) @(posedge sys_clk);
		end
	endtask : tk
	task automatic mag(input logic [15:0] v);
		m = '0;
		m[0].harm[0] = v;
		meas <= m;
	endtask : mag
	task automatic st(input logic [2:0] x);
		chk(32'({stage_blocked[0], stage_trip[0], stage_start[0]}), 32'(x));
	endtask : st
	initial begin
		#3_000_000;
		errors++;
		complete_run();
	end
	initial begin
		repeat (10) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		apb(1'b0, 8'h10, 32'h0);
		chk(r, 32'(CFG_RST));
		apb(1'b0, 8'h14, 32'h0);
		chk(r, 32'h0000_0014);
		foreach (rows[i]) begin
			apb(1'b1, 8'h10, 32'(rows[i].cf));
			apb(1'b1, 8'h14, 32'(rows[i].pk));
			m = '0;
			m[rows[i].ch].harm[rows[i].ix] = rows[i].mg;
			m[rows[i].ch].fund = rows[i].fd;
			meas <= m;
			tk(2);
			chk(32'(stage_start[0]), 32'(rows[i].ex));
			mag(16'h0);
			tk(2);
		end
		apb(1'b1, 8'h18, 32'h3);
		apb(1'b1, 8'h10, 32'h003);
		apb(1'b1, 8'h14, 32'h64);
		apb(1'b1, 8'h04, 32'hF);
		mag(16'h65);
		tk(1);
		st(3'h1);
		mag(16'h62);
		tk(1);
		st(3'h1);
		tk(3);
		st(3'h3);
		apb(1'b0, 8'h54, 32'h0);
		chk(r, 32'h0000_0062);
		apb(1'b0, 8'h58, 32'h0);
		chk(r, 32'h0000_0003);
		apb(1'b0, 8'h5C, 32'h0);
		chk(r, 32'hFFFF_FFFE);
		block_in <= 4'h1;
		tk(2);
		st(3'h4);
		block_in <= 4'h0;
		mag(16'h0);
		tk(2);
		st(3'h0);
		block_in <= 4'h1;
		tk(1);
		mag(16'h65);
		tk(1);
		st(3'h4);
		for (int k = 0; k < 3; k++) begin
			apb(1'b0, 8'h90 + 8'(4 * k), 32'h0);
			chk(r, (k == 2) ? 32'h2 : 32'h1);
		end
		// Nine ON transitions so far: five row starts, start, trip, two blocks
		apb(1'b0, 8'h08, 32'h0);
		chk(r, 32'h0000_0900);
		apb(1'b1, 8'h08, 32'h80);
		apb(1'b0, 8'hD8, 32'h0);
		chk(r & 32'h0000_FFFF, 32'h0000_0088);
		apb(1'b0, 8'hD4, 32'h0);
		chk(r & 32'h0000_FFFF, 32'h0000_0065);
		block_in <= 4'h0;
		mag(16'h0);
		tk(2);
		// Inverse time: excess 1.00 per cycle against delay 3
		apb(1'b1, 8'h10, 32'h013);
		mag(16'hC8);
		repeat (150) @(posedge sys_clk);
		tk(2);
		st(3'h1);
		tk(1);
		st(3'h3);
		chk(event_stamp, 32'(n_tick));
		ce <= 1'b0;
		mag(16'h0);
		tk(1);
		st(3'h3);
		ce <= 1'b1;
		tk(2);
		st(3'h0);
		apb(1'b1, 8'h20, 32'h00F);
		tk(1);
		chk(32'(stage_trip[1]), 32'h0);
		apb(1'b1, 8'h00, 32'h1);
		tk(1);
		chk(32'(stage_trip[1]), 32'h1);
		sys_rst <= 1'b1;
		@(posedge sys_clk);
		chk(32'(stage_trip[1]), 32'h0);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		apb(1'b0, 8'h00, 32'h0);
		chk(r, 32'h0000_0000);
		apb(1'b0, 8'hE0, 32'h0);
		chk(32'(e), 32'h1);
		complete_run();
	end
endmodule : test_harmonic_overcurrent_stage
